// >>> verilog/hub_strap_map.vh
// Register offsets, field positions, reset values and timing counts of the strap and port power block
`ifndef HUB_STRAP_MAP_VH
`define HUB_STRAP_MAP_VH

`define HUB_NPORTS        4
`define PORT_FIELD_W      4
`define CLK_MHZ           250
`define RST_MIN_NS        1000
`define RST_MIN_CYC       ((`RST_MIN_NS * `CLK_MHZ + 999) / 1000)
`define OC_FILTER_NS      1000
`define OC_FILTER_CYC     ((`OC_FILTER_NS * `CLK_MHZ + 999) / 1000)
`define CNT_W             10

`define WB_AW             6
`define REG_CTRL          6'h00
`define REG_STRAP         6'h04
`define REG_PORT          6'h08
`define REG_IRQ_STAT      6'h0c
`define REG_IRQ_MASK      6'h10

`define CTRL_PWR_LSB      0
`define CTRL_OC_AUTO_BIT  8
`define CTRL_PWR_RESET    4'h0
`define CTRL_OC_AUTO_RST  1'b1

`define ST_DIS_LSB        0
`define ST_CHG_LSB        4
`define ST_CODE_LSB       8
`define ST_SEL_LSB        10
`define ST_COMPOUND_BIT   12
`define ST_VALID_BIT      13

`define PT_PWR_LSB        0
`define PT_OC_LSB         4
`define PT_TRIP_LSB       8
`define PT_FIXED_LSB      12
`define PT_EXT_LSB        16

`define IRQ_W             6
`define IRQ_OC_LSB        0
`define IRQ_LATCH_BIT     4
`define IRQ_SHORT_BIT     5
`define IRQ_MASK_RESET    6'h00

`endif

// >>> verilog/overcurrent_filter.v
// Per-port qualifier of the active-low over-current sense inputs
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_map.vh"

module overcurrent_filter #(
    parameter                  NPORTS     = `HUB_NPORTS,
    parameter [`CNT_W-1:0]     FILTER_CYC = `OC_FILTER_CYC
) (
    input  wire                core_clk,
    input  wire                rst,
    input  wire                clr,
    input  wire [NPORTS-1:0]   overcurrent_sense_n,
    output wire [NPORTS-1:0]   oc_level,
    output wire [NPORTS-1:0]   oc_rise
);

    genvar g;
    generate
        for (g = 0; g < NPORTS; g = g + 1)
        begin : port_filter
            reg [`CNT_W-1:0] cnt_r;
            reg              lvl_r;
            reg              rise_r;
            wire             hit = (cnt_r == FILTER_CYC - 1'b1);

            always @(posedge core_clk or posedge rst)
            begin
                if (rst)
                begin
                    cnt_r  <= {`CNT_W{1'b0}};
                    lvl_r  <= 1'b0;
                    rise_r <= 1'b0;
                end
                else if (clr)
                begin
                    cnt_r  <= {`CNT_W{1'b0}};
                    lvl_r  <= 1'b0;
                    rise_r <= 1'b0;
                end
                else if (!overcurrent_sense_n[g]) // [RULE_06] [RULE_07]
                begin
                    if (!lvl_r)
                        cnt_r <= cnt_r + 1'b1;
                    lvl_r  <= lvl_r | hit;
                    rise_r <= hit & ~lvl_r;
                end
                else
                begin
                    cnt_r  <= {`CNT_W{1'b0}};
                    lvl_r  <= 1'b0;
                    rise_r <= 1'b0;
                end
            end

            assign oc_level[g] = lvl_r;
            assign oc_rise[g]  = rise_r;
        end
    endgenerate

endmodule

`default_nettype wire

// >>> verilog/strap_capture.v
// Samples the strap pins once, on release of the active-low hub reset
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_map.vh"

module strap_capture #(
    parameter                  NPORTS  = `HUB_NPORTS,
    parameter [`CNT_W-1:0]     MIN_CYC = `RST_MIN_CYC
) (
    input  wire                core_clk,
    input  wire                rst,
    input  wire                hub_reset_n,
    input  wire                strap_enable,
    input  wire [NPORTS-1:0]   port_disable_strap_plus,
    input  wire [NPORTS-1:0]   port_disable_strap_minus,
    input  wire [NPORTS-1:0]   charge_support_strap,
    input  wire                fixed_port_code_bit0,
    input  wire                fixed_port_code_bit1,
    input  wire                config_method_sel_0,
    input  wire                config_method_sel_1,
    output reg  [NPORTS-1:0]   port_disabled,
    output reg  [NPORTS-1:0]   charge_enabled,
    output reg  [1:0]          fixed_port_code,
    output reg  [1:0]          config_method_sel,
    output reg                 straps_valid,
    output reg                 release_pulse,
    output reg                 short_reset_pulse
);

    reg  [`CNT_W-1:0] low_cnt_r;
    reg               prev_r;
    wire              release_now = hub_reset_n & ~prev_r;

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            prev_r            <= 1'b0;
            low_cnt_r         <= {`CNT_W{1'b0}};
            port_disabled     <= {NPORTS{1'b0}};
            charge_enabled    <= {NPORTS{1'b0}};
            fixed_port_code   <= 2'h0;
            config_method_sel <= 2'h0;
            straps_valid      <= 1'b0;
            release_pulse     <= 1'b0;
            short_reset_pulse <= 1'b0;
        end
        else
        begin
            prev_r            <= hub_reset_n;
            release_pulse     <= release_now;
            short_reset_pulse <= release_now & (low_cnt_r != {`CNT_W{1'b0}}) & (low_cnt_r < MIN_CYC); // [RULE_12]
            if (!hub_reset_n)
            begin
                straps_valid <= 1'b0;
                if (low_cnt_r < MIN_CYC)
                    low_cnt_r <= low_cnt_r + 1'b1;
            end
            else if (release_now) // [RULE_15]
            begin
                low_cnt_r         <= {`CNT_W{1'b0}};
                straps_valid      <= 1'b1;
                config_method_sel <= {config_method_sel_1, config_method_sel_0}; // [RULE_13] [RULE_14]
                if (strap_enable) // [RULE_11]
                begin
                    port_disabled   <= port_disable_strap_plus & port_disable_strap_minus; // [RULE_01] [RULE_02]
                    charge_enabled  <= charge_support_strap; // [RULE_03]
                    fixed_port_code <= {fixed_port_code_bit1, fixed_port_code_bit0}; // [RULE_08]
                end
                else
                begin
                    port_disabled   <= {NPORTS{1'b0}};
                    charge_enabled  <= {NPORTS{1'b0}};
                    fixed_port_code <= 2'h0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> verilog/hub_strap_and_port_power_pins.v
// Strap latching, port power and over-current handling with a Wishbone register file
`timescale 1ns/1ps
`default_nettype none
`include "hub_strap_map.vh"

// Summary of operation
// RULE_01 - At reset release, sample each port's disable straps when sampling is enabled.
// RULE_02 - A port is disabled only when both its plus and minus straps read high.
// RULE_03 - Latch one charge strap per port; 1 enables charging support, 0 disables it.
// RULE_04 - Ports with charging support are run with an external power controller.
// RULE_05 - Drive one power enable output per downstream port.
// RULE_06 - Each port has an over-current sense input that flags over-current on it.
// RULE_07 - Names ending in _n are asserted low and negated high.
// RULE_08 - At reset release sample the two fixed-port straps together as one code.
// RULE_09 - Code 00 none, 01 port one, 10 ports one-two, 11 ports one-three if present.
// RULE_10 - Any fixed port makes the hub report itself as a compound device.
// RULE_11 - Port disable, charge and fixed-port straps are sampled only when enabled.
// RULE_12 - A low hub reset resets the whole block; it must stay low at least 1 us. Here the latched strap values and config_method hold until the next release.
// RULE_13 - Latch the first config select strap on the reset rising edge.
// RULE_14 - Latch the second config select strap on the same edge; both pick the method.
// RULE_15 - Latched straps stay constant from reset release until reset is asserted again.
module hub_strap_and_port_power_pins #(
    parameter                  NPORTS        = `HUB_NPORTS,
    parameter [`CNT_W-1:0]     RST_MIN_CYC   = `RST_MIN_CYC,
    parameter [`CNT_W-1:0]     OC_FILTER_CYC = `OC_FILTER_CYC
) (
    input  wire                core_clk,
    input  wire                rst,
    input  wire                wb_cyc_i,
    input  wire                wb_stb_i,
    input  wire                wb_we_i,
    input  wire [`WB_AW-1:0]   wb_adr_i,
    input  wire [3:0]          wb_sel_i,
    input  wire [31:0]         wb_dat_i,
    output wire [31:0]         wb_dat_o,
    output wire                wb_ack_o,
    output wire                irq,
    input  wire                hub_reset_n,
    input  wire                strap_enable,
    input  wire [NPORTS-1:0]   port_disable_strap_plus,
    input  wire [NPORTS-1:0]   port_disable_strap_minus,
    input  wire [NPORTS-1:0]   charge_support_strap,
    input  wire                fixed_port_code_bit0,
    input  wire                fixed_port_code_bit1,
    input  wire                config_method_sel_0,
    input  wire                config_method_sel_1,
    input  wire [NPORTS-1:0]   overcurrent_sense_n,
    output wire [NPORTS-1:0]   port_power_enable,
    output wire [NPORTS-1:0]   port_ext_power_ctrl,
    output wire [1:0]          config_method,
    output wire                compound_device,
    output wire [NPORTS-1:0]   fixed_port_mask
);

    localparam FW = `PORT_FIELD_W;

    // Ports that follow each fixed-port code
    function [FW-1:0] fixed_decode;
        input [1:0] code;
        begin
            case (code)
                2'h0:    fixed_decode = 4'h0;
                2'h1:    fixed_decode = 4'h1;
                2'h2:    fixed_decode = 4'h3;
                2'h3:    fixed_decode = 4'h7;
                default: fixed_decode = 4'h0;
            endcase
        end
    endfunction

    wire                dev_clr = ~hub_reset_n; // [RULE_07] [RULE_12]

    wire [NPORTS-1:0]   dis_w;
    wire [NPORTS-1:0]   chg_w;
    wire [1:0]          code_w;
    wire [1:0]          sel_w;
    wire                valid_w;
    wire                release_w;
    wire                short_w;
    wire [NPORTS-1:0]   oc_lvl_w;
    wire [NPORTS-1:0]   oc_rise_w;

    strap_capture #(
        .NPORTS            (NPORTS),
        .MIN_CYC           (RST_MIN_CYC)
    ) u_strap (
        .core_clk                 (core_clk),
        .rst                      (rst),
        .hub_reset_n              (hub_reset_n),
        .strap_enable             (strap_enable),
        .port_disable_strap_plus  (port_disable_strap_plus),
        .port_disable_strap_minus (port_disable_strap_minus),
        .charge_support_strap     (charge_support_strap),
        .fixed_port_code_bit0     (fixed_port_code_bit0),
        .fixed_port_code_bit1     (fixed_port_code_bit1),
        .config_method_sel_0      (config_method_sel_0),
        .config_method_sel_1      (config_method_sel_1),
        .port_disabled            (dis_w),
        .charge_enabled           (chg_w),
        .fixed_port_code          (code_w),
        .config_method_sel        (sel_w),
        .straps_valid             (valid_w),
        .release_pulse            (release_w),
        .short_reset_pulse        (short_w)
    );

    overcurrent_filter #(
        .NPORTS            (NPORTS),
        .FILTER_CYC        (OC_FILTER_CYC)
    ) u_ocf (
        .core_clk            (core_clk),
        .rst                 (rst),
        .clr                 (dev_clr),
        .overcurrent_sense_n (overcurrent_sense_n),
        .oc_level            (oc_lvl_w),
        .oc_rise             (oc_rise_w)
    );

    // Port vectors widened to the fixed register field width
    reg  [FW-1:0]       dis4;
    reg  [FW-1:0]       chg4;
    reg  [FW-1:0]       oc4;
    reg  [FW-1:0]       ocr4;
    reg  [FW-1:0]       present4;
    integer             i;

    always @*
    begin
        dis4     = {FW{1'b0}};
        chg4     = {FW{1'b0}};
        oc4      = {FW{1'b0}};
        ocr4     = {FW{1'b0}};
        present4 = {FW{1'b0}};
        for (i = 0; i < NPORTS; i = i + 1)
        begin
            dis4[i]     = dis_w[i];
            chg4[i]     = chg_w[i];
            oc4[i]      = oc_lvl_w[i];
            ocr4[i]     = oc_rise_w[i];
            present4[i] = 1'b1;
        end
    end

    reg  [FW-1:0]       pwr_req_r;
    reg                 oc_auto_r;
    reg  [FW-1:0]       trip_r;
    reg  [FW-1:0]       trip_nxt;
    reg  [FW-1:0]       pwr_r;
    reg  [FW-1:0]       pwr_nxt;
    reg  [FW-1:0]       ext_r;
    reg  [FW-1:0]       fixed_r;
    reg                 compound_r;
    reg  [`IRQ_W-1:0]   irq_stat_r;
    reg  [`IRQ_W-1:0]   irq_stat_nxt;
    reg  [`IRQ_W-1:0]   irq_mask_r;
    reg                 irq_r;
    reg                 ack_r;
    reg  [31:0]         dat_r;
    reg  [31:0]         rd_mux;

    wire                req      = wb_cyc_i & wb_stb_i;
    wire                commit   = req & ack_r;
    wire                wr_ctrl  = commit & wb_we_i & (wb_adr_i == `REG_CTRL);
    wire                wr_port  = commit & wb_we_i & (wb_adr_i == `REG_PORT);
    wire                wr_mask  = commit & wb_we_i & (wb_adr_i == `REG_IRQ_MASK);
    wire                rd_irq   = commit & ~wb_we_i & (wb_adr_i == `REG_IRQ_STAT);
    wire [FW-1:0]       fixed4   = fixed_decode(code_w) & present4; // [RULE_09]

    // Read data, captured when ack rises
    always @*
    begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `REG_CTRL:
            begin
                rd_mux[`CTRL_PWR_LSB +: FW]   = pwr_req_r;
                rd_mux[`CTRL_OC_AUTO_BIT]     = oc_auto_r;
            end
            `REG_STRAP:
            begin
                rd_mux[`ST_DIS_LSB +: FW]     = dis4;
                rd_mux[`ST_CHG_LSB +: FW]     = chg4;
                rd_mux[`ST_CODE_LSB +: 2]     = code_w;
                rd_mux[`ST_SEL_LSB +: 2]      = sel_w;
                rd_mux[`ST_COMPOUND_BIT]      = compound_r;
                rd_mux[`ST_VALID_BIT]         = valid_w;
            end
            `REG_PORT:
            begin
                rd_mux[`PT_PWR_LSB +: FW]     = pwr_r;
                rd_mux[`PT_OC_LSB +: FW]      = oc4;
                rd_mux[`PT_TRIP_LSB +: FW]    = trip_r;
                rd_mux[`PT_FIXED_LSB +: FW]   = fixed_r;
                rd_mux[`PT_EXT_LSB +: FW]     = ext_r;
            end
            `REG_IRQ_STAT:
                rd_mux[`IRQ_W-1:0]            = irq_stat_r;
            `REG_IRQ_MASK:
                rd_mux[`IRQ_W-1:0]            = irq_mask_r;
            default:
                rd_mux = 32'h0000_0000;
        endcase
    end

    // Trip flags and event status: a set always beats a clear
    always @*
    begin
        trip_nxt = trip_r;
        if (wr_port & wb_sel_i[1])
            trip_nxt = trip_nxt & ~wb_dat_i[`PT_TRIP_LSB +: FW];
        trip_nxt = trip_nxt | ocr4; // [RULE_06]

        irq_stat_nxt = irq_stat_r;
        if (rd_irq)
            irq_stat_nxt = irq_stat_nxt & ~dat_r[`IRQ_W-1:0];
        irq_stat_nxt[`IRQ_OC_LSB +: FW] = irq_stat_nxt[`IRQ_OC_LSB +: FW] | ocr4;
        irq_stat_nxt[`IRQ_LATCH_BIT]    = irq_stat_nxt[`IRQ_LATCH_BIT] | release_w;
        irq_stat_nxt[`IRQ_SHORT_BIT]    = irq_stat_nxt[`IRQ_SHORT_BIT] | short_w;
    end

    // Power stays off for disabled ports and while reset holds the straps unknown
    always @*
    begin
        pwr_nxt = (pwr_req_r | chg4) & ~dis4 & present4 & {FW{valid_w}}; // [RULE_05] [RULE_04]
        if (oc_auto_r)
            pwr_nxt = pwr_nxt & ~trip_nxt; // [RULE_06]
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            if (req & ~ack_r)
                dat_r <= rd_mux;
        end
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pwr_req_r  <= `CTRL_PWR_RESET;
            oc_auto_r  <= `CTRL_OC_AUTO_RST;
            trip_r     <= {FW{1'b0}};
            pwr_r      <= {FW{1'b0}};
            ext_r      <= {FW{1'b0}};
            fixed_r    <= {FW{1'b0}};
            compound_r <= 1'b0;
            irq_stat_r <= {`IRQ_W{1'b0}};
            irq_mask_r <= `IRQ_MASK_RESET;
            irq_r      <= 1'b0;
        end
        else if (dev_clr) // [RULE_12]
        begin
            pwr_req_r  <= `CTRL_PWR_RESET;
            oc_auto_r  <= `CTRL_OC_AUTO_RST;
            trip_r     <= {FW{1'b0}};
            pwr_r      <= {FW{1'b0}};
            ext_r      <= {FW{1'b0}};
            fixed_r    <= {FW{1'b0}};
            compound_r <= 1'b0;
            irq_stat_r <= {`IRQ_W{1'b0}};
            irq_mask_r <= `IRQ_MASK_RESET;
            irq_r      <= 1'b0;
        end
        else
        begin
            if (wr_ctrl & wb_sel_i[0])
                pwr_req_r <= wb_dat_i[`CTRL_PWR_LSB +: FW];
            if (wr_ctrl & wb_sel_i[1])
                oc_auto_r <= wb_dat_i[`CTRL_OC_AUTO_BIT];
            if (wr_mask & wb_sel_i[0])
                irq_mask_r <= wb_dat_i[`IRQ_W-1:0];
            trip_r     <= trip_nxt;
            pwr_r      <= pwr_nxt;
            ext_r      <= chg4 & ~dis4; // [RULE_04]
            fixed_r    <= fixed4;
            compound_r <= |fixed4; // [RULE_10]
            irq_stat_r <= irq_stat_nxt;
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign wb_dat_o            = dat_r;
    assign wb_ack_o            = ack_r;
    assign irq                 = irq_r;
    assign port_power_enable   = pwr_r[NPORTS-1:0]; // [RULE_05]
    assign port_ext_power_ctrl = ext_r[NPORTS-1:0];
    assign config_method       = sel_w; // [RULE_13] [RULE_14]
    assign compound_device     = compound_r;
    assign fixed_port_mask     = fixed_r[NPORTS-1:0];

endmodule

`default_nettype wire

// >>> tb/hub_strap_chk.sv
// Assertion checker for strap latching, port power and bus answers
`timescale 1ns/1ps
`default_nettype none
module hub_strap_chk #(
    parameter       NPORTS        = 4,
    parameter [9:0] OC_FILTER_CYC = 10'd250
) (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              hub_reset_n,
    input wire logic              strap_enable,
    input wire logic [NPORTS-1:0] port_disable_strap_plus,
    input wire logic [NPORTS-1:0] port_disable_strap_minus,
    input wire logic [NPORTS-1:0] charge_support_strap,
    input wire logic              fixed_port_code_bit0,
    input wire logic              fixed_port_code_bit1,
    input wire logic              config_method_sel_0,
    input wire logic              config_method_sel_1,
    input wire logic [NPORTS-1:0] overcurrent_sense_n,
    input wire logic [NPORTS-1:0] port_power_enable,
    input wire logic [NPORTS-1:0] port_ext_power_ctrl,
    input wire logic [1:0]        config_method,
    input wire logic              compound_device,
    input wire logic [NPORTS-1:0] fixed_port_mask
);
    reg  [2:0]        up_cnt_r;
    reg  [9:0]        oc_lo_r;
    reg  [NPORTS-1:0] dis_r;
    reg  [NPORTS-1:0] chg_r;
    reg  [1:0]        code_r;
    reg  [1:0]        sel_r;
    wire [3:0]        dec = (4'h1 << code_r) - 4'h1;
    wire              up  = hub_reset_n && up_cnt_r > 3'h3;

    // Cycles since hub reset release, saturating
    always @(posedge core_clk or posedge rst)
    begin
        if (rst || !hub_reset_n)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7)
            up_cnt_r <= up_cnt_r + 3'h1;
    end

    // Run length of over-current on port one
    always @(posedge core_clk or posedge rst)
    begin
        if (rst || overcurrent_sense_n[0])
            oc_lo_r <= 10'h0;
        else if (oc_lo_r != 10'h3ff)
            oc_lo_r <= oc_lo_r + 10'h1;
    end

    // Own copy of the pins at the release edge
    always @(posedge core_clk)
    begin
        if (hub_reset_n && up_cnt_r == 3'h0)
        begin
            dis_r  <= port_disable_strap_plus & port_disable_strap_minus & {NPORTS{strap_enable}};
            chg_r  <= charge_support_strap & {NPORTS{strap_enable}};
            code_r <= {fixed_port_code_bit1, fixed_port_code_bit0} & {2{strap_enable}};
            sel_r  <= {config_method_sel_1, config_method_sel_0};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_ack_pulse: assert property (s_req |=> s_pulse) else $error("ack not a single cycle answer");
    a_latch_stable:
        assert property (up |-> $stable(config_method) && $stable(fixed_port_mask) && $stable(port_ext_power_ctrl))
        else $error("latched strap output moved");
    a_cfg_latch:
        assert property (up |-> config_method == sel_r) else $error("config method differs from pins");
    a_fixed_decode:
        assert property (up |-> fixed_port_mask == dec[NPORTS-1:0]) else $error("fixed port mask wrong");
    a_compound_flag:
        assert property (up |-> compound_device == (code_r != 2'b00)) else $error("compound flag wrong");
    a_ext_ctrl:
        assert property (up |-> port_ext_power_ctrl == (chg_r & ~dis_r)) else $error("ext power ctrl wrong");
    a_dis_unpowered:
        assert property (up |-> (port_power_enable & dis_r) == 0) else $error("disabled port powered");
    a_oc_cut:
        assert property (oc_lo_r == OC_FILTER_CYC |-> ##[1:6] !port_power_enable[0]) else $error("no power cut");
    a_reset_clears:
        assert property (!hub_reset_n |=> port_power_enable == 0 && !compound_device) else $error("reset not applied");
endmodule

bind hub_strap_and_port_power_pins hub_strap_chk #(.NPORTS(NPORTS), .OC_FILTER_CYC(OC_FILTER_CYC)) u_chk (.*);
`default_nettype wire

// >>> tb/board_model.sv
// Board straps, port power switches and current monitors
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic        core_clk,
    input  wire logic        hub_reset_n,
    input  wire logic [15:0] strap_cfg,
    input  wire logic [3:0]  oc_fault,
    input  wire logic [3:0]  port_power_enable,
    output wire logic [15:0] strap_pins,
    output wire logic [3:0]  overcurrent_sense_n
);
    reg [1:0] hold_r = 2'h0;
    reg       flip_r = 1'b0;

    always @(posedge core_clk)
    begin
        if (!hub_reset_n)
            hold_r <= 2'h0;
        else if (hold_r != 2'h3)
            hold_r <= hold_r + 2'h1;
        flip_r <= !flip_r;
    end

    // Shared pins carry traffic once the strap window is over
    assign strap_pins = (hold_r == 2'h3) ? (strap_cfg ^ {16{flip_r}}) : strap_cfg;
    // Monitor pulls low only while the switch conducts
    assign overcurrent_sense_n = ~(oc_fault & port_power_enable);
endmodule
`default_nettype wire

// >>> tb/hub_strap_and_port_power_pins_tb.sv
// Self-checking bench for the strap and port power block
`timescale 1ns/1ps
`default_nettype none
module hub_strap_and_port_power_pins_tb;
    reg         core_clk = 1'b0;
    reg         rst = 1'b1;
    reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    reg  [5:0]  wb_adr_i = 6'h00;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0;
    reg         hub_reset_n = 1'b0, strap_enable = 1'b0;
    reg  [15:0] strap_cfg = 16'h0;
    reg  [3:0]  oc_fault = 4'h0;
    reg  [31:0] rd;
    wire [31:0] wb_dat_o;
    wire [15:0] strap_pins;
    wire [3:0]  port_disable_strap_plus  = strap_pins[3:0];
    wire [3:0]  port_disable_strap_minus = strap_pins[7:4];
    wire [3:0]  charge_support_strap     = strap_pins[11:8];
    wire        fixed_port_code_bit0 = strap_pins[12], fixed_port_code_bit1 = strap_pins[13];
    wire        config_method_sel_0 = strap_pins[14], config_method_sel_1 = strap_pins[15];
    wire        wb_ack_o, irq, compound_device;
    wire [3:0]  overcurrent_sense_n, port_power_enable, port_ext_power_ctrl, fixed_port_mask;
    wire [1:0]  config_method;
    integer     err_count = 0, num_checks = 0;

    hub_strap_and_port_power_pins #(.NPORTS(4), .RST_MIN_CYC(10'd250), .OC_FILTER_CYC(10'd8)) DUT (.*);
    board_model partner (.*);

    always #2 core_clk = ~core_clk;

    task check(input string what, input [31:0] exp, input [31:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task wb(input w, input [5:0] a, input [3:0] s, input [31:0] d);
        integer i;
    begin
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge core_clk);
        for (i = 1; wb_ack_o !== 1'b1; i = i + 1)
            @(posedge core_clk);
        rd = wb_dat_o;
        check("bus ack", 32'd2, i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge core_clk);
    end
    endtask

    task hub_rst(input integer n, input en, input [15:0] c);
    begin
        strap_enable <= en;
        strap_cfg <= c;
        hub_reset_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        hub_reset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    end
    endtask

    task t_straps(input [15:0] c, input en);
        reg [3:0]  dis, chg;
        reg [1:0]  code;
        reg [31:0] exp_st;
    begin
        hub_rst(260, en, c);
        dis = c[3:0] & c[7:4] & {4{en}};
        chg = c[11:8] & {4{en}};
        code = c[13:12] & {2{en}};
        exp_st = {18'h0, 1'b1, code != 2'b00, c[15:14], code, chg, dis};
        wb(1'b0, 6'h04, 4'hf, 32'h0);
        check("strap reg", exp_st, rd);
        check("fixed mask", (4'h1 << code) - 4'h1, fixed_port_mask);
        check("compound", code != 2'b00, compound_device);
        check("config method", c[15:14], config_method);
        check("ext ctrl", chg & ~dis, port_ext_power_ctrl);
        check("power", chg & ~dis, port_power_enable);
        check("irq masked", 32'h0, irq);
        wb(1'b0, 6'h0c, 4'hf, 32'h0);
        check("latch event", 32'h10, rd);
        wb(1'b0, 6'h0c, 4'hf, 32'h0);
        check("event cleared", 32'h0, rd);
        repeat (5) @(posedge core_clk);
        wb(1'b0, 6'h04, 4'hf, 32'h0);
        check("strap held", exp_st, rd);
    end
    endtask

    task t_power;
    begin
        wb(1'b0, 6'h00, 4'hf, 32'h0);
        check("ctrl reset", 32'h100, rd);
        wb(1'b1, 6'h00, 4'h0, 32'hf);
        repeat (2) @(posedge core_clk);
        check("lane off", 32'h1, port_power_enable);
        wb(1'b1, 6'h00, 4'h1, 32'hf);
        repeat (2) @(posedge core_clk);
        check("power on", 32'h9, port_power_enable);
        wb(1'b1, 6'h3c, 4'hf, 32'hffff_ffff);
        wb(1'b0, 6'h3c, 4'hf, 32'h0);
        check("unmapped", 32'h0, rd);
        wb(1'b0, 6'h08, 4'hf, 32'h0);
        check("port reg", 32'h0001_7009, rd);
    end
    endtask

    task t_oc;
        integer i;
    begin
        wb(1'b1, 6'h10, 4'h1, 32'h1);
        oc_fault <= 4'h1;
        for (i = 0; i < 100 && irq !== 1'b1; i = i + 1)
            @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        check("oc irq", 32'h1, irq);
        check("oc power cut", 32'h8, port_power_enable);
        wb(1'b0, 6'h08, 4'hf, 32'h0);
        check("trip", 32'h1, rd[11:8]);
        wb(1'b0, 6'h0c, 4'hf, 32'h0);
        check("oc event", 32'h1, rd);
        repeat (2) @(posedge core_clk);
        check("irq clear", 32'h0, irq);
        oc_fault <= 4'h0;
        wb(1'b1, 6'h08, 4'h2, 32'h100);
        repeat (2) @(posedge core_clk);
        check("power back", 32'h9, port_power_enable);
    end
    endtask

    task t_short;
    begin
        hub_rst(3, 1'b1, 16'h3166);
        check("irq masked", 32'h0, irq);
        wb(1'b0, 6'h0c, 4'hf, 32'h0);
        check("short reset", 32'h30, rd);
        wb(1'b0, 6'h10, 4'hf, 32'h0);
        check("mask reset", 32'h0, rd);
    end
    endtask

    task print_verdict;
    begin
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        t_straps(16'h4a35, 1'b1);
        t_straps(16'h968f, 1'b1);
        t_straps(16'heff0, 1'b1);
        t_straps(16'hffff, 1'b0);
        t_straps(16'h3166, 1'b1);
        t_power;
        t_oc;
        t_short;
        print_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count = err_count + 1;
        print_verdict;
    end
endmodule
`default_nettype wire
